// ---- pkg/can_filt_pkg.sv ----
// Package: register map, field layout and types of the CAN filter/interrupt block
// How it works
// - Mode 0: two filters on all 29 extended ID bits plus RTR, IDE, SRR.
// - Mode 1: four filters on standard 11 bits plus RTR, or 14 extended MSBs.
// - Mode 2: eight filters on the first eight identifier bits only.
// - Closed mode: no new frame is accepted; only a frame already in the back buffer can still reach the front and set rx_full_flag.
// - Each compared bit must equal its accept bit unless its mask bit is set.
// - First bank gives lower-numbered hits, second bank the upper-numbered ones.
// - Accepted message sets rx_full_flag and loads the three-bit filter_hit_code.
// - Several matching filters report the lowest-numbered one.
// - Eleven sources, each with own enable, drive wake, error, receive, transmit.
// - Transmit request while any empty buffer flag has its enable set.
// - Receive request and rx_full_flag rise right after EOF of accepted frame.
// - Bus activity during internal sleep sets wake_flag.
// - Rx and tx warning flags set when their error counter reaches 96.
// - Rx and tx passive flags set when their counter exceeds 127.
// - bus_off_flag sets when the transmit error counter exceeds 255.
// - Requests stay high while any enabled flag is set, gated by global mask.
// - Writing one to a flag bit clears it; handler acknowledges this way.
// - A write-one clear is void while the setting condition persists.
// - Error counters cannot be written through the register interface.
// - Config, timing, filter control, accept and mask writes need soft_reset_lock.
// - can_tx_pin forced recessive while the processor is in stop mode.
// - Accepted frame with both buffers full is dropped and sets overrun_flag.
// - Back-to-front copy happens only while rx_full_flag is clear.
package can_filt_pkg;

    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [7:0] ADDR_MODULE_CTRL_A = 8'h00;
    localparam logic [7:0] ADDR_MODULE_CTRL_B = 8'h04;
    localparam logic [7:0] ADDR_BIT_TIMING_A  = 8'h08;
    localparam logic [7:0] ADDR_BIT_TIMING_B  = 8'h0c;
    localparam logic [7:0] ADDR_RX_FLAGS      = 8'h10;
    localparam logic [7:0] ADDR_RX_IRQ_EN     = 8'h14;
    localparam logic [7:0] ADDR_TX_FLAGS      = 8'h18;
    localparam logic [7:0] ADDR_TX_CTRL       = 8'h1c;
    localparam logic [7:0] ADDR_FILTER_CTRL   = 8'h20;
    localparam logic [7:0] ADDR_ACCEPT_LO     = 8'h24;
    localparam logic [7:0] ADDR_ACCEPT_HI     = 8'h28;
    localparam logic [7:0] ADDR_MASK_LO       = 8'h2c;
    localparam logic [7:0] ADDR_MASK_HI       = 8'h30;
    localparam logic [7:0] ADDR_ERR_CNT       = 8'h34;

    // ****************************************
    // Field positions and constants
    // ****************************************
    localparam int FLG_RX_FULL    = 0;
    localparam int FLG_OVERRUN    = 1;
    localparam int FLG_BUS_OFF    = 2;
    localparam int FLG_TX_PASSIVE = 3;
    localparam int FLG_RX_PASSIVE = 4;
    localparam int FLG_TX_WARN    = 5;
    localparam int FLG_RX_WARN    = 6;
    localparam int FLG_WAKE       = 7;
    localparam int MODE_LSB       = 4;
    localparam int TX_BUFS        = 3;
    localparam logic [8:0] WARN_LIMIT    = 9'd96;
    localparam logic [8:0] PASSIVE_LIMIT = 9'd127;
    localparam logic [8:0] BUS_OFF_LIMIT = 9'd255;
    localparam logic [1:0] RESP_OKAY     = 2'b00;
    localparam logic [1:0] RESP_SLVERR   = 2'b10;
    localparam logic       RECESSIVE     = 1'b1;
    localparam logic [7:0] CTRL_A_RST    = 8'h01;

    typedef enum logic [1:0] {
        MODE_TWO_32   = 2'b00,
        MODE_FOUR_16  = 2'b01,
        MODE_EIGHT_8  = 2'b10,
        MODE_CLOSED   = 2'b11
    } filt_mode_t;

    // Received frame identity, valid with the end-of-frame strobe
    typedef struct packed {
        logic [28:0] id;
        logic        ide;
        logic        rtr;
        logic        srr;
    } rx_frame_t;

    // Error counters from the protocol engine
    typedef struct packed {
        logic [8:0] tx_err;
        logic [8:0] rx_err;
    } err_cnt_t;

endpackage

// ---- core/can_acceptance_filter_irq.sv ----
// CAN acceptance filter, interrupt flags and configuration lock behind AXI4-Lite
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
module can_acceptance_filter_irq (
    // Clock and reset
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_rst_n,
    // AXI4-Lite write address and data
    input  wire logic                   i_axi_awvalid,
    output logic                        o_axi_awready,
    input  wire logic [7:0]             i_axi_awaddr,
    input  wire logic                   i_axi_wvalid,
    output logic                        o_axi_wready,
    input  wire logic [31:0]            i_axi_wdata,
    input  wire logic [3:0]             i_axi_wstrb,
    // AXI4-Lite write response
    output logic                        o_axi_bvalid,
    input  wire logic                   i_axi_bready,
    output logic [1:0]                  o_axi_bresp,
    // AXI4-Lite read
    input  wire logic                   i_axi_arvalid,
    output logic                        o_axi_arready,
    input  wire logic [7:0]             i_axi_araddr,
    output logic                        o_axi_rvalid,
    input  wire logic                   i_axi_rready,
    output logic [31:0]                 o_axi_rdata,
    output logic [1:0]                  o_axi_rresp,
    // Protocol engine side
    input  wire logic                   i_frame_ok,
    input  wire can_filt_pkg::rx_frame_t i_frame,
    input  wire can_filt_pkg::err_cnt_t i_err_cnt,
    input  wire logic [2:0]             i_tx_buf_empty,
    input  wire logic                   i_sleep_mode,
    input  wire logic                   i_engine_tx,
    // Pins and processor state
    input  wire logic                   i_can_rx_pin,
    input  wire logic                   i_stop_mode,
    input  wire logic                   i_global_irq_mask,
    // Outputs
    output logic                        o_can_tx_pin,
    output logic                        o_rx_copy,
    output logic                        o_irq_wake,
    output logic                        o_irq_err,
    output logic                        o_irq_rx,
    output logic                        o_irq_tx,
    output logic [7:0]                  o_module_ctrl_b,
    output logic [15:0]                 o_bit_timing
);
    import can_filt_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0]  ctrl_a_q;
    logic [7:0]  ctrl_b_q;
    logic [7:0]  timing_a_q;
    logic [7:0]  timing_b_q;
    logic [7:0]  flags_q;
    logic [7:0]  flags_d;
    logic [7:0]  irq_en_q;
    logic [2:0]  tx_irq_en_q;
    filt_mode_t  mode_q;
    logic [2:0]  hit_code_q;
    logic [2:0]  back_hit_q;
    logic        back_full_q;
    logic [31:0] accept_q [2];
    logic [31:0] mask_q [2];
    logic        rx_meta_q;
    logic        rx_sync_q;
    logic        rx_prev_q;
    logic        aw_have_q;
    logic        w_have_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        soft_reset_lock;
    logic        wr_fire;
    logic [7:0]  clr_mask;
    logic [31:0] rd_data;
    logic        rd_hit;
    logic        wr_hit;

    assign soft_reset_lock = ctrl_a_q[0];

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    // Address and data are taken in either order; response waits for both
    assign wr_fire = aw_have_q && w_have_q && !o_axi_bvalid;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            o_axi_awready <= 1'b0;
            o_axi_wready  <= 1'b0;
            o_axi_bvalid  <= 1'b0;
            o_axi_bresp   <= RESP_OKAY;
        end else begin
            o_axi_awready <= !aw_have_q && !(o_axi_awready && i_axi_awvalid);
            o_axi_wready  <= !w_have_q && !(o_axi_wready && i_axi_wvalid);
            if (o_axi_awready && i_axi_awvalid) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= i_axi_awaddr;
            end
            if (o_axi_wready && i_axi_wvalid) begin
                w_have_q <= 1'b1;
                w_data_q <= i_axi_wdata;
                w_strb_q <= i_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_q     <= 1'b0;
                w_have_q      <= 1'b0;
                o_axi_awready <= 1'b0;
                o_axi_wready  <= 1'b0;
                o_axi_bvalid  <= 1'b1;
                o_axi_bresp   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (o_axi_bvalid && i_axi_bready) begin
                o_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        case (aw_addr_q)
            ADDR_MODULE_CTRL_A, ADDR_MODULE_CTRL_B, ADDR_BIT_TIMING_A, ADDR_BIT_TIMING_B,
            ADDR_RX_FLAGS, ADDR_RX_IRQ_EN, ADDR_TX_FLAGS, ADDR_TX_CTRL, ADDR_FILTER_CTRL,
            ADDR_ACCEPT_LO, ADDR_ACCEPT_HI, ADDR_MASK_LO, ADDR_MASK_HI, ADDR_ERR_CNT: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_comb begin
        rd_hit  = 1'b1;
        rd_data = 32'h0000_0000;
        case (i_axi_araddr)
            ADDR_MODULE_CTRL_A: rd_data[7:0] = ctrl_a_q;
            ADDR_MODULE_CTRL_B: rd_data[7:0] = ctrl_b_q;
            ADDR_BIT_TIMING_A:  rd_data[7:0] = timing_a_q;
            ADDR_BIT_TIMING_B:  rd_data[7:0] = timing_b_q;
            ADDR_RX_FLAGS:      rd_data[7:0] = flags_q;
            ADDR_RX_IRQ_EN:     rd_data[7:0] = irq_en_q;
            ADDR_TX_FLAGS:      rd_data[2:0] = i_tx_buf_empty;
            ADDR_TX_CTRL:       rd_data[2:0] = tx_irq_en_q;
            ADDR_FILTER_CTRL:   rd_data[7:0] = {2'b00, mode_q, 1'b0, hit_code_q};
            ADDR_ACCEPT_LO:     rd_data      = accept_q[0];
            ADDR_ACCEPT_HI:     rd_data      = accept_q[1];
            ADDR_MASK_LO:       rd_data      = mask_q[0];
            ADDR_MASK_HI:       rd_data      = mask_q[1];
            ADDR_ERR_CNT:       rd_data      = {7'h00, i_err_cnt.tx_err, 7'h00, i_err_cnt.rx_err};
            default:            rd_hit       = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_axi_arready <= 1'b0;
            o_axi_rvalid  <= 1'b0;
            o_axi_rdata   <= 32'h0000_0000;
            o_axi_rresp   <= RESP_OKAY;
        end else begin
            o_axi_arready <= !o_axi_rvalid && !(o_axi_arready && i_axi_arvalid);
            if (o_axi_arready && i_axi_arvalid) begin
                o_axi_rvalid <= 1'b1;
                o_axi_rdata  <= rd_data;
                o_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (o_axi_rvalid && i_axi_rready) begin
                o_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // Control registers and configuration lock
    // ****************************************
    // Error counters are read-only inputs; no write path reaches them
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ctrl_a_q    <= CTRL_A_RST;
            ctrl_b_q    <= 8'h00;
            timing_a_q  <= 8'h00;
            timing_b_q  <= 8'h00;
            irq_en_q    <= 8'h00;
            tx_irq_en_q <= 3'b000;
            mode_q      <= MODE_TWO_32;
            accept_q[0] <= 32'h0000_0000;
            accept_q[1] <= 32'h0000_0000;
            mask_q[0]   <= 32'h0000_0000;
            mask_q[1]   <= 32'h0000_0000;
        end else if (wr_fire && w_strb_q[0]) begin
            case (aw_addr_q)
                ADDR_MODULE_CTRL_A: ctrl_a_q    <= w_data_q[7:0];
                ADDR_RX_IRQ_EN:     irq_en_q    <= w_data_q[7:0];
                ADDR_TX_CTRL:       tx_irq_en_q <= w_data_q[2:0];
                default: begin
                    // Online writes to configuration are dropped silently
                    if (soft_reset_lock) begin
                        case (aw_addr_q)
                            ADDR_MODULE_CTRL_B: ctrl_b_q   <= w_data_q[7:0];
                            ADDR_BIT_TIMING_A:  timing_a_q <= w_data_q[7:0];
                            ADDR_BIT_TIMING_B:  timing_b_q <= w_data_q[7:0];
                            ADDR_FILTER_CTRL:   mode_q     <= filt_mode_t'(w_data_q[MODE_LSB +: 2]);
                            ADDR_ACCEPT_LO:     accept_q[0] <= w_data_q;
                            ADDR_ACCEPT_HI:     accept_q[1] <= w_data_q;
                            ADDR_MASK_LO:       mask_q[0]   <= w_data_q;
                            ADDR_MASK_HI:       mask_q[1]   <= w_data_q;
                            default: ;
                        endcase
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Identifier acceptance filter
    // ****************************************
    logic [31:0] id_word;
    logic [7:0]  hits;
    logic [2:0]  hit_idx;
    logic        hit_any;
    logic [31:0] eq [2];

    // Frame laid out as the bank sees it, byte 0 in the top byte
    always_comb begin
        if (i_frame.ide) begin
            id_word = {i_frame.id[28:18], i_frame.srr, i_frame.ide, i_frame.id[17:0], i_frame.rtr};
        end else begin
            id_word = {i_frame.id[10:0], i_frame.rtr, i_frame.ide, 19'h00000};
        end
    end

    always_comb begin
        hits = 8'h00;
        for (int b = 0; b < 2; b++) begin
            // Mask bit set makes the position don't care
            eq[b] = ~(({4{id_word[31:24]}} ^ accept_q[b]) & ~mask_q[b]);
            case (mode_q)
                MODE_TWO_32: begin
                    eq[b] = ~((id_word ^ accept_q[b]) & ~mask_q[b]);
                    hits[b] = &eq[b];
                end
                MODE_FOUR_16: begin
                    eq[b] = ~(({2{id_word[31:16]}} ^ accept_q[b]) & ~mask_q[b]);
                    hits[2*b]   = &eq[b][31:16];
                    hits[2*b+1] = &eq[b][15:0];
                end
                MODE_EIGHT_8: begin
                    for (int k = 0; k < 4; k++) begin
                        hits[4*b+k] = &eq[b][31-8*k -: 8];
                    end
                end
                default: hits = 8'h00;
            endcase
        end
    end

    always_comb begin
        hit_idx = 3'd0;
        hit_any = |hits;
        for (int i = 7; i >= 0; i--) begin
            if (hits[i]) begin
                hit_idx = 3'(i);
            end
        end
    end

    // ****************************************
    // Receive buffers and flags
    // ****************************************
    logic accept_ev;
    logic copy_now;
    logic store_back;
    logic overrun_ev;
    logic [7:0] cond;

    assign accept_ev  = i_frame_ok && hit_any && (mode_q != MODE_CLOSED);
    assign clr_mask   = (wr_fire && w_strb_q[0] && aw_addr_q == ADDR_RX_FLAGS) ? w_data_q[7:0] : 8'h00;
    // Copy only into an empty front buffer and never while asleep
    assign copy_now   = !flags_q[FLG_RX_FULL] && !i_sleep_mode && (back_full_q || accept_ev);
    assign store_back = accept_ev && (flags_q[FLG_RX_FULL] || i_sleep_mode || back_full_q);
    assign overrun_ev = accept_ev && back_full_q && !copy_now;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            rx_meta_q <= RECESSIVE;
            rx_sync_q <= RECESSIVE;
            rx_prev_q <= RECESSIVE;
        end else begin
            rx_meta_q <= i_can_rx_pin;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
        end
    end

    always_comb begin
        cond = 8'h00;
        cond[FLG_WAKE]       = i_sleep_mode && (rx_sync_q != rx_prev_q);
        cond[FLG_RX_WARN]    = i_err_cnt.rx_err >= WARN_LIMIT;
        cond[FLG_TX_WARN]    = i_err_cnt.tx_err >= WARN_LIMIT;
        cond[FLG_RX_PASSIVE] = i_err_cnt.rx_err > PASSIVE_LIMIT;
        cond[FLG_TX_PASSIVE] = i_err_cnt.tx_err > PASSIVE_LIMIT;
        cond[FLG_BUS_OFF]    = i_err_cnt.tx_err > BUS_OFF_LIMIT;
        cond[FLG_OVERRUN]    = overrun_ev;
        cond[FLG_RX_FULL]    = copy_now;
        // Ones clear, zeros keep; a live condition beats the clear
        flags_d = (flags_q & ~clr_mask) | cond;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            flags_q     <= 8'h00;
            back_full_q <= 1'b0;
            back_hit_q  <= 3'd0;
            hit_code_q  <= 3'd0;
            o_rx_copy   <= 1'b0;
        end else begin
            flags_q   <= flags_d;
            o_rx_copy <= copy_now;
            if (copy_now) begin
                hit_code_q <= back_full_q ? back_hit_q : hit_idx;
            end
            if (store_back && !(back_full_q && !copy_now)) begin
                back_full_q <= 1'b1;
                back_hit_q  <= hit_idx;
            end else if (copy_now && back_full_q) begin
                back_full_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Interrupt requests and transmit pin
    // ****************************************
    logic [7:0] pend;
    assign pend = flags_q & irq_en_q;

    // Requests follow enabled flags and drop under the global mask
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_irq_wake <= 1'b0;
            o_irq_err  <= 1'b0;
            o_irq_rx   <= 1'b0;
            o_irq_tx   <= 1'b0;
        end else begin
            o_irq_wake <= !i_global_irq_mask && pend[FLG_WAKE];
            o_irq_err  <= !i_global_irq_mask && |pend[FLG_RX_WARN:FLG_OVERRUN];
            o_irq_rx   <= !i_global_irq_mask && pend[FLG_RX_FULL];
            o_irq_tx   <= !i_global_irq_mask && |(i_tx_buf_empty & tx_irq_en_q);
        end
    end

    // Stop mode must never leave the bus driven dominant
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_can_tx_pin    <= RECESSIVE;
            o_module_ctrl_b <= 8'h00;
            o_bit_timing    <= 16'h0000;
        end else begin
            o_can_tx_pin    <= i_stop_mode ? RECESSIVE : i_engine_tx;
            o_module_ctrl_b <= ctrl_b_q;
            o_bit_timing    <= {timing_b_q, timing_a_q};
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    sequence s_clear_flags;
        wr_fire && w_strb_q[0] && aw_addr_q == ADDR_RX_FLAGS;
    endsequence

    property p_closed_no_rx;
        mode_q == MODE_CLOSED && !back_full_q && !flags_q[FLG_RX_FULL] |=> !flags_q[FLG_RX_FULL];
    endproperty
    a_closed_no_rx: assert property (p_closed_no_rx) else $error("rx full set in closed mode");

    property p_rx_full_irq;
        copy_now && irq_en_q[FLG_RX_FULL] && !i_global_irq_mask ##1 !i_global_irq_mask |=> o_irq_rx;
    endproperty
    a_rx_full_irq: assert property (p_rx_full_irq) else $error("rx irq missing after accept");

    property p_lowest_hit;
        copy_now && !back_full_q |=> hit_code_q == $past(hit_idx) && flags_q[FLG_RX_FULL];
    endproperty
    a_lowest_hit: assert property (p_lowest_hit) else $error("hit code not loaded");

    property p_warn_persists;
        s_clear_flags ##0 i_err_cnt.rx_err >= WARN_LIMIT |=> flags_q[FLG_RX_WARN];
    endproperty
    a_warn_persists: assert property (p_warn_persists) else $error("warn flag cleared while active");

    property p_w1c;
        s_clear_flags ##0 (w_data_q[FLG_OVERRUN] && !overrun_ev) |=> !flags_q[FLG_OVERRUN];
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear");

    property p_lock;
        wr_fire && !soft_reset_lock && aw_addr_q == ADDR_ACCEPT_LO |=> $stable(accept_q[0]);
    endproperty
    a_lock: assert property (p_lock) else $error("locked register changed");

    property p_stop_recessive;
        i_stop_mode |=> o_can_tx_pin == RECESSIVE;
    endproperty
    a_stop_recessive: assert property (p_stop_recessive) else $error("tx pin dominant in stop");

    property p_bus_off;
        i_err_cnt.tx_err > BUS_OFF_LIMIT |=> flags_q[FLG_BUS_OFF];
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("bus off flag missing");

    property p_overrun;
        overrun_ev |=> flags_q[FLG_OVERRUN] && back_full_q;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");

    property p_tx_irq;
        !i_global_irq_mask && |(i_tx_buf_empty & tx_irq_en_q) |=> o_irq_tx;
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("tx irq missing");

    property p_global_mask;
        i_global_irq_mask |=> !o_irq_err && !o_irq_rx && !o_irq_wake && !o_irq_tx;
    endproperty
    a_global_mask: assert property (p_global_mask) else $error("irq under global mask");

endmodule // can_acceptance_filter_irq

// ---- verification/can_engine_model.sv ----
// Protocol engine model: end-of-frame strobes
`timescale 1ns/100ps
module can_engine_model (
    // Clock
    input  wire logic                    i_clk_sys,
    // Frame strobe
    output logic                         o_frame_ok,
    output can_filt_pkg::rx_frame_t      o_frame
);
    import can_filt_pkg::*;
    initial begin
        o_frame_ok = 1'b0;
        o_frame    = '0;
    end
    // One-cycle strobe right at end of frame
    task automatic send(input rx_frame_t f);
        @(posedge i_clk_sys);
        o_frame    <= f;
        o_frame_ok <= 1'b1;
        @(posedge i_clk_sys);
        o_frame_ok <= 1'b0;
        o_frame    <= ~f; // Inverted after strobe
    endtask
endmodule // can_engine_model

// ---- verification/can_acceptance_filter_irq_bench.sv ----
// Register-level bench of the CAN filter and interrupt block
`timescale 1ns/100ps
module can_acceptance_filter_irq_bench;
    import can_filt_pkg::*;
    logic            clk, rst_n, awv, wv, bry, arv, rry, stop, gmsk, slp, crx;
    logic            awr, wrd, bv, arr, rv, txp, irq_e, irq_r, irq_t, irq_w, fok;
    logic [15:0]     btm;
    logic [7:0]      awa, ara, mcb;
    logic [31:0]     wd, rd, rdat;
    logic [1:0]      rsp, rrsp, brsp;
    logic [2:0]      temp;
    err_cnt_t        err;
    rx_frame_t       frm;
    int              failures, n_checks;
    can_engine_model i_eng (.i_clk_sys(clk), .o_frame_ok(fok), .o_frame(frm));
    can_acceptance_filter_irq i_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_axi_awvalid(awv),
        .o_axi_awready(awr), .i_axi_awaddr(awa), .i_axi_wvalid(wv), .o_axi_wready(wrd),
        .i_axi_wdata(wd), .i_axi_wstrb(4'hf), .o_axi_bvalid(bv), .i_axi_bready(bry), .o_axi_bresp(brsp),
        .i_axi_arvalid(arv), .o_axi_arready(arr), .i_axi_araddr(ara), .o_axi_rvalid(rv),
        .i_axi_rready(rry), .o_axi_rdata(rdat), .o_axi_rresp(rrsp), .i_frame_ok(fok), .i_frame(frm),
        .i_err_cnt(err), .i_tx_buf_empty(temp), .i_sleep_mode(slp), .i_engine_tx(1'b0),
        .i_can_rx_pin(crx), .i_stop_mode(stop), .i_global_irq_mask(gmsk), .o_can_tx_pin(txp),
        .o_rx_copy(), .o_irq_wake(irq_w), .o_irq_err(irq_e), .o_irq_rx(irq_r), .o_irq_tx(irq_t),
        .o_module_ctrl_b(mcb), .o_bit_timing(btm));
    // ****************************************
    // Bus tasks and compare
    // ****************************************
    task automatic results();
        if (failures == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Bounded waits: a hung handshake ends the run
    // Leading edge: a following call must not see the last answer again
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        {awa, wd, awv, wv, bry} <= {a, d, 3'b111};
        k = 0;
        do begin
            @(posedge clk);
            k++;
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (k < 40 && !(bv && bry));
        bry <= 1'b0;
        if (!(bv && bry)) failures++;
        if (!(bv && bry)) results();
    endtask
    task automatic rd_reg(input logic [7:0] a);
        int k;
        @(posedge clk);
        {ara, arv, rry} <= {a, 2'b11};
        k = 0;
        do begin
            @(posedge clk);
            k++;
            if (arr) arv <= 1'b0;
            {rd, rsp} = {rdat, rrsp};
        end while (k < 40 && !(rv && rry));
        rry <= 1'b0;
        if (!(rv && rry)) failures++;
        if (!(rv && rry)) results();
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {rst_n, awv, wv, bry, arv, rry, stop, gmsk, slp, awa, ara, wd, temp, err} = '0;
        {failures, n_checks} = '0;
        crx = 1'b1;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wr(ADDR_RX_IRQ_EN, 32'ha1);
        wr(ADDR_ACCEPT_LO, 32'h00080000);
        wr(ADDR_MASK_LO, 32'h2);
        wr(ADDR_ACCEPT_HI, 32'h33000000);
        wr(ADDR_MASK_HI, 32'h0);
        i_eng.send({29'h2, 3'h4});
        rd_reg(ADDR_RX_FLAGS);
        chk(rd, 32'h0);
        i_eng.send({29'h1, 3'h4});
        rd_reg(ADDR_RX_FLAGS);
        chk(rd, 32'h1);
        rd_reg(ADDR_FILTER_CTRL);
        chk(rd & 32'h7, 32'h0);
        chk(irq_r, 1'b1);
        wr(ADDR_RX_FLAGS, 32'h0);
        rd_reg(ADDR_RX_FLAGS);
        chk(rd, 32'h1);
        wr(ADDR_RX_FLAGS, 32'h1);
        rd_reg(ADDR_RX_FLAGS);
        chk({rd[0], irq_r}, 32'h0);
        wr(ADDR_FILTER_CTRL, 32'h10);
        i_eng.send({29'h198, 3'h0});
        rd_reg(ADDR_FILTER_CTRL);
        chk(rd & 32'h7, 32'h2);
        wr(ADDR_RX_FLAGS, 32'h1);
        wr(ADDR_FILTER_CTRL, 32'h20);
        wr(ADDR_ACCEPT_LO, 32'h11223344);
        i_eng.send({29'h0, 3'h0});
        rd_reg(ADDR_FILTER_CTRL);
        chk(rd & 32'h7, 32'h5);
        i_eng.send({29'h0, 3'h0});
        i_eng.send({29'h0, 3'h0});
        rd_reg(ADDR_RX_FLAGS);
        chk(rd, 32'h3);
        wr(ADDR_RX_FLAGS, 32'h3);
        rd_reg(ADDR_RX_FLAGS);
        chk(rd, 32'h1);
        wr(ADDR_RX_FLAGS, 32'h1);
        wr(ADDR_FILTER_CTRL, 32'h30);
        i_eng.send({8'h33, 24'h0});
        rd_reg(ADDR_RX_FLAGS);
        chk(rd, 32'h0);
        err <= {9'd96, 9'd0};
        wr(ADDR_ERR_CNT, 32'hffffffff);
        rd_reg(ADDR_ERR_CNT);
        chk(rd, 32'h00600000);
        wr(ADDR_RX_FLAGS, 32'h20);
        rd_reg(ADDR_RX_FLAGS);
        chk({rd[30:0], irq_e}, 32'h41);
        err <= {9'd256, 9'd128};
        rd_reg(ADDR_RX_FLAGS);
        chk(rd, 32'h7c);
        err <= '0;
        wr(ADDR_RX_FLAGS, 32'hff);
        rd_reg(ADDR_RX_FLAGS);
        chk(rd, 32'h0);
        {slp, crx} <= 2'b10;
        repeat (4) @(posedge clk);
        rd_reg(ADDR_RX_FLAGS);
        chk({rd[30:0], irq_w}, 32'h101);
        slp <= 1'b0;
        wr(ADDR_TX_CTRL, 32'h2);
        temp <= 3'b001;
        repeat (3) @(posedge clk);
        chk({irq_t, txp}, 2'b00);
        {temp, stop} <= 4'b0101;
        repeat (3) @(posedge clk);
        chk({irq_t, txp}, 2'b11);
        gmsk <= 1'b1;
        repeat (3) @(posedge clk);
        chk(irq_t, 1'b0);
        rd_reg(8'h3c);
        chk(rsp, RESP_SLVERR);
        wr(8'h3c, 32'h0);
        chk(brsp, RESP_SLVERR);
        wr(ADDR_MODULE_CTRL_B, 32'h5a);
        wr(ADDR_BIT_TIMING_A, 32'h5a);
        wr(ADDR_MODULE_CTRL_A, 32'h0);
        wr(ADDR_MODULE_CTRL_B, 32'ha5);
        wr(ADDR_BIT_TIMING_A, 32'ha5);
        chk({btm, mcb}, 32'h005a5a);
        results();
    end
endmodule // can_acceptance_filter_irq_bench
